// File: verilog/irq_prio_map.svh
// Register offsets, field positions, reset values and codes of the priority block
`ifndef IRQ_PRIO_MAP_SVH
`define IRQ_PRIO_MAP_SVH

// Register indices; the byte address is four times the index
`define PRI_IDX_SECOND 6'h01
`define PRI_IDX_THIRD 6'h02
`define PRI_IDX_FOURTH 6'h03
`define PRI_IDX_FIFTH 6'h04

// Reset value and writable bits of each register
`define PRI_RESET 16'h0000
`define PRI_WMASK_SECOND 16'h0003
`define PRI_WMASK_THIRD 16'hF3FF
`define PRI_WMASK_FOURTH 16'hFFF0
`define PRI_WMASK_FIFTH 16'h00FF

// Field encoding
`define PRI_CODE_OFF 2'h0
`define PRI_LEVEL_MAX 2'h2

// Field low bit positions
`define FLD_FREQ_SYNTH 0
`define FLD_RX_FULL 14
`define FLD_RX_ERROR 12
`define FLD_TX_IDLE 8
`define FLD_TX_EMPTY 6
`define FLD_SS_TX_EMPTY 4
`define FLD_SS_RX_FULL 2
`define FLD_PORT_A 0
`define FLD_CONV_A 14
`define FLD_TIMER3 12
`define FLD_TIMER2 10
`define FLD_TIMER1 8
`define FLD_TIMER0 6
`define FLD_TWOWIRE 4
`define FLD_PULSE_FAULT 6
`define FLD_PULSE_RELOAD 4
`define FLD_CONV_ZERO 2
`define FLD_CONV_B 0

`endif

// File: verilog/irq_prio_pkg.sv
// Types shared by the interrupt priority level block
package irq_prio_pkg;
  // Source numbering, one entry per level field
  typedef enum {
    SRC_FREQ_SYNTH, SRC_RX_FULL, SRC_RX_ERROR, SRC_TX_IDLE, SRC_TX_EMPTY,
    SRC_SS_TX_EMPTY, SRC_SS_RX_FULL, SRC_PORT_A, SRC_CONV_A, SRC_TIMER3,
    SRC_TIMER2, SRC_TIMER1, SRC_TIMER0, SRC_TWOWIRE, SRC_PULSE_FAULT,
    SRC_PULSE_RELOAD, SRC_CONV_ZERO, SRC_CONV_B, SRC_COUNT
  } src_id_e;

  // Request handed to the prioritisation logic
  typedef struct packed {
    logic active;
    logic [1:0] level;
  } src_req_s;

  typedef logic [15:0] prio_word_t;
endpackage

// File: verilog/irq_priority_level_config.sv
// APB register block holding the per-source interrupt priority levels
`timescale 1ns/1ps
`include "irq_prio_map.svh"

// Summary of operation
// - Field 00 disables, 01 is level 0, 10 level 1, 11 level 2.
// - Every level field resets to the disabled code.
// - Frequency synthesizer lock field sits in bits 1-0 of the second register.
// - Third register: receiver full in 15-14, receiver error in 13-12.
// - Third register: transmitter idle in 9-8, transmitter empty in 7-6.
// - Third register: sync serial transmit empty 5-4, receive full 3-2.
// - Third register: port A level in bits 1-0.
// - Reserved bits read as zero and ignore writes.
// - Fourth register: converter A done 15-14, timer 3 in 13-12.
// - Fourth register: timer 2 in 11-10, timer 1 in 9-8, timer 0 in 7-6.
// - Fourth register: two-wire address match level in bits 5-4.
// - Fifth register: pulse fault in 7-6, pulse reload in 5-4.
// - Fifth register: converter zero-crossing or limit level in bits 3-2.
// - Fifth register: converter B done level in bits 1-0.
module irq_priority_level_config #(
  parameter int NUM_SRC = irq_prio_pkg::SRC_COUNT,
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [NUM_SRC-1:0] src_irq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output irq_prio_pkg::src_req_s [NUM_SRC-1:0] src_req
);

  // ----------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------
  irq_prio_pkg::prio_word_t second_q;
  irq_prio_pkg::prio_word_t third_q;
  irq_prio_pkg::prio_word_t fourth_q;
  irq_prio_pkg::prio_word_t fifth_q;

  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  irq_prio_pkg::src_req_s [NUM_SRC-1:0] src_req_q;

  // ----------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------
  logic [ADDR_W-1:0] addr_second;
  logic [ADDR_W-1:0] addr_third;
  logic [ADDR_W-1:0] addr_fourth;
  logic [ADDR_W-1:0] addr_fifth;
  logic hit_second;
  logic hit_third;
  logic hit_fourth;
  logic hit_fifth;
  logic hit_any;
  logic setup_ph;
  logic wr_acc;
  logic [15:0] lane_mask;

  // Word index scaled to a byte address
  assign addr_second = ADDR_W'({`PRI_IDX_SECOND, 2'h0});
  assign addr_third = ADDR_W'({`PRI_IDX_THIRD, 2'h0});
  assign addr_fourth = ADDR_W'({`PRI_IDX_FOURTH, 2'h0});
  assign addr_fifth = ADDR_W'({`PRI_IDX_FIFTH, 2'h0});

  assign hit_second = (paddr == addr_second);
  assign hit_third = (paddr == addr_third);
  assign hit_fourth = (paddr == addr_fourth);
  assign hit_fifth = (paddr == addr_fifth);
  assign hit_any = hit_second | hit_third | hit_fourth | hit_fifth;

  // Setup is seen once; the write commits only at the completing edge
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pready_q & pwrite & ~pslverr_q;

  // Only the two low byte lanes carry register bits
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // ----------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------
  // One wait-free access: ready rises in the access phase after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
    end else begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph & ~hit_any;
    end
  end

  // Read data captured at setup; no write can land in between
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph) begin
      if (pwrite || !hit_any) begin
        prdata_q <= 32'h0000_0000;
      end else if (hit_second) begin
        prdata_q <= {16'h0000, second_q};
      end else if (hit_third) begin
        prdata_q <= {16'h0000, third_q};
      end else if (hit_fourth) begin
        prdata_q <= {16'h0000, fourth_q};
      end else begin
        prdata_q <= {16'h0000, fifth_q};
      end
    end
  end

  // ----------------------------------------------------------
  // Priority registers
  // ----------------------------------------------------------
  // Write masks keep reserved bits at zero, so reads need no extra gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_q <= `PRI_RESET;
    end else if (wr_acc && hit_second) begin
      second_q <= (second_q & ~lane_mask) |
        (pwdata[15:0] & lane_mask & `PRI_WMASK_SECOND);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      third_q <= `PRI_RESET;
    end else if (wr_acc && hit_third) begin
      third_q <= (third_q & ~lane_mask) |
        (pwdata[15:0] & lane_mask & `PRI_WMASK_THIRD);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fourth_q <= `PRI_RESET;
    end else if (wr_acc && hit_fourth) begin
      fourth_q <= (fourth_q & ~lane_mask) |
        (pwdata[15:0] & lane_mask & `PRI_WMASK_FOURTH);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifth_q <= `PRI_RESET;
    end else if (wr_acc && hit_fifth) begin
      fifth_q <= (fifth_q & ~lane_mask) |
        (pwdata[15:0] & lane_mask & `PRI_WMASK_FIFTH);
    end
  end

  // ----------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------
  logic [1:0] fld [NUM_SRC];

  // Each source picks its two bits out of its register
  assign fld[irq_prio_pkg::SRC_FREQ_SYNTH] = second_q[`FLD_FREQ_SYNTH +: 2];
  assign fld[irq_prio_pkg::SRC_RX_FULL] = third_q[`FLD_RX_FULL +: 2];
  assign fld[irq_prio_pkg::SRC_RX_ERROR] = third_q[`FLD_RX_ERROR +: 2];
  assign fld[irq_prio_pkg::SRC_TX_IDLE] = third_q[`FLD_TX_IDLE +: 2];
  assign fld[irq_prio_pkg::SRC_TX_EMPTY] = third_q[`FLD_TX_EMPTY +: 2];
  assign fld[irq_prio_pkg::SRC_SS_TX_EMPTY] = third_q[`FLD_SS_TX_EMPTY +: 2];
  assign fld[irq_prio_pkg::SRC_SS_RX_FULL] = third_q[`FLD_SS_RX_FULL +: 2];
  assign fld[irq_prio_pkg::SRC_PORT_A] = third_q[`FLD_PORT_A +: 2];
  assign fld[irq_prio_pkg::SRC_CONV_A] = fourth_q[`FLD_CONV_A +: 2];
  assign fld[irq_prio_pkg::SRC_TIMER3] = fourth_q[`FLD_TIMER3 +: 2];
  assign fld[irq_prio_pkg::SRC_TIMER2] = fourth_q[`FLD_TIMER2 +: 2];
  assign fld[irq_prio_pkg::SRC_TIMER1] = fourth_q[`FLD_TIMER1 +: 2];
  assign fld[irq_prio_pkg::SRC_TIMER0] = fourth_q[`FLD_TIMER0 +: 2];
  assign fld[irq_prio_pkg::SRC_TWOWIRE] = fourth_q[`FLD_TWOWIRE +: 2];
  assign fld[irq_prio_pkg::SRC_PULSE_FAULT] = fifth_q[`FLD_PULSE_FAULT +: 2];
  assign fld[irq_prio_pkg::SRC_PULSE_RELOAD] = fifth_q[`FLD_PULSE_RELOAD +: 2];
  assign fld[irq_prio_pkg::SRC_CONV_ZERO] = fifth_q[`FLD_CONV_ZERO +: 2];
  assign fld[irq_prio_pkg::SRC_CONV_B] = fifth_q[`FLD_CONV_B +: 2];

  // ----------------------------------------------------------
  // Request decode toward the prioritiser
  // ----------------------------------------------------------
  // Registered so the prioritiser sees clean levels; costs one cycle
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          src_req_q[gi] <= '0;
        end else begin
          src_req_q[gi].active <= src_irq[gi] & (fld[gi] != `PRI_CODE_OFF);
          // Code minus one yields levels 0 to 2 only
          src_req_q[gi].level <= (fld[gi] == `PRI_CODE_OFF) ? 2'h0 : fld[gi] - 2'h1;
        end
      end

      // Disabled field never lets a request through
      a_off_suppress: assert property (@(posedge pclk) disable iff (!presetn)
        (fld[gi] == `PRI_CODE_OFF) |=> !src_req_q[gi].active)
        else $error("disabled source raised a request");

      // Enabled request carries the field code less one
      a_level_decode: assert property (@(posedge pclk) disable iff (!presetn)
        (src_irq[gi] && fld[gi] != `PRI_CODE_OFF) |=>
        (src_req_q[gi].active && src_req_q[gi].level == $past(fld[gi]) - 2'h1))
        else $error("request level does not match its field");

      // No source may be presented above level 2
      a_level_ceiling: assert property (@(posedge pclk) disable iff (!presetn)
        src_req_q[gi].level <= `PRI_LEVEL_MAX)
        else $error("request level above the ceiling");

      // A disabled source also reports level zero, so no stale level leaks out
      a_off_level: assert property (@(posedge pclk) disable iff (!presetn)
        (fld[gi] == `PRI_CODE_OFF) |=> (src_req_q[gi].level == 2'h0))
        else $error("disabled source reports a level");

      // A quiet source raises nothing, whatever its field holds
      a_quiet_source: assert property (@(posedge pclk) disable iff (!presetn)
        !src_irq[gi] |=> !src_req_q[gi].active)
        else $error("request without a source event");
    end
  endgenerate

  // ----------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign src_req = src_req_q;

  // ----------------------------------------------------------
  // Checks on the register file
  // ----------------------------------------------------------
  // All fields come out of reset disabled
  a_reset_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> ((second_q | third_q | fourth_q | fifth_q) == 16'h0000))
    else $error("priority field not disabled after reset");

  // Reserved ranges hold zero whatever was written
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (second_q[15:2] == 14'h0000) && (third_q[11:10] == 2'h0) &&
    (fourth_q[3:0] == 4'h0) && (fifth_q[15:8] == 8'h00))
    else $error("reserved bits not zero");

  // Full-lane write to the third register lands in one access
  a_write_third: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_third && pstrb[1:0] == 2'h3) |=>
    (third_q == ($past(pwdata[15:0]) & `PRI_WMASK_THIRD)))
    else $error("third register write not applied");

  // Port A field tracks the low bits written two cycles before the output
  a_port_a_path: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_third && pstrb[0] && pwdata[1:0] == 2'h3) ##1
    src_irq[irq_prio_pkg::SRC_PORT_A] |=>
    (src_req_q[irq_prio_pkg::SRC_PORT_A].level == `PRI_LEVEL_MAX))
    else $error("port A field not at bits 1-0");

  // A read completes with current contents and reserved bits clear
  a_read_fifth: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_fifth) |=>
    (pready_q && prdata_q == {16'h0000, fifth_q} && prdata_q[15:8] == 8'h00))
    else $error("fifth register read mismatch");

  // Setup is answered ready in the next cycle, error only for holes
  a_ready_timing: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph |=> (pready_q && (pslverr_q == !$past(hit_any))))
    else $error("access not answered in one cycle");

  // Unmapped writes change nothing
  a_unmapped_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pslverr_q) |=>
    ($stable(second_q) && $stable(third_q) && $stable(fourth_q) && $stable(fifth_q)))
    else $error("unmapped access altered a register");

  // ----------------------------------------------------------
  // Checks on the bus answer and on per-register writes
  // ----------------------------------------------------------
  // Ready is a single pulse; a held level would complete a phantom transfer
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready_q |=> !pready_q)
    else $error("ready held for more than one cycle");

  // An error answer only ever comes together with ready
  a_error_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr_q |-> pready_q)
    else $error("error flagged without ready");

  // No select, no answer in the following cycle
  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !psel |=> (!pready_q && !pslverr_q))
    else $error("answer without a request");

  // The upper half of the read word never carries data
  a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
    pready_q |-> (prdata_q[31:16] == 16'h0000))
    else $error("upper read half not zero");

  // Holes read as zero so stale data from an earlier read cannot leak
  a_read_hole: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !hit_any) |=> (prdata_q == 32'h0000_0000))
    else $error("unmapped read returned data");

  // Second register reads back its lock field in place
  a_read_second: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_second) |=> (prdata_q == {16'h0000, second_q}))
    else $error("second register read mismatch");

  // Third register reads back its serial and port fields in place
  a_read_third: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_third) |=> (prdata_q == {16'h0000, third_q}))
    else $error("third register read mismatch");

  // Fourth register reads back its timer and converter fields in place
  a_read_fourth: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_fourth) |=> (prdata_q == {16'h0000, fourth_q}))
    else $error("fourth register read mismatch");

  // The lock field lives in the low lane only, so one strobe suffices
  a_write_second: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_second && pstrb[0]) |=>
    (second_q == ($past(pwdata[15:0]) & `PRI_WMASK_SECOND)))
    else $error("second register write not applied");

  // Full-lane write to the fourth register lands in one access
  a_write_fourth: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_fourth && pstrb[1:0] == 2'h3) |=>
    (fourth_q == ($past(pwdata[15:0]) & `PRI_WMASK_FOURTH)))
    else $error("fourth register write not applied");

  // All fifth-register fields sit in the low lane
  a_write_fifth: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_fifth && pstrb[0]) |=>
    (fifth_q == ($past(pwdata[15:0]) & `PRI_WMASK_FIFTH)))
    else $error("fifth register write not applied");

  // An unstrobed lane keeps its old fields
  a_lane_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_third && !pstrb[1]) |=> (third_q[15:8] == $past(third_q[15:8])))
    else $error("unstrobed lane was written");

endmodule // irq_priority_level_config

// File: sim/irq_source_model.sv
// Behavioural model of the peripheral interrupt sources that feed the priority block
`timescale 1ns/1ps

module irq_source_model #(
  parameter int NUM_SRC = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NUM_SRC-1:0] pattern,
  output logic [NUM_SRC-1:0] src_irq
);
  // Requests leave a flop just after the edge, as a real peripheral's would;
  // driving them combinationally from the bench would race the sampling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_irq <= '0;
    end else begin
      src_irq <= pattern;
    end
  end
endmodule // irq_source_model

// File: sim/tb_irq_priority_level_config.sv
// Self-checking testbench for the interrupt priority level block
`timescale 1ns/1ps
`include "irq_prio_map.svh"

module tb_irq_priority_level_config;
  localparam int N = irq_prio_pkg::SRC_COUNT;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [N-1:0] irq_pattern = '1;
  logic [N-1:0] src_irq;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  irq_prio_pkg::src_req_s [N-1:0] src_req;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  logic [15:0] img [1:4];
  logic [15:0] wmask [1:4] = '{`PRI_WMASK_SECOND, `PRI_WMASK_THIRD, `PRI_WMASK_FOURTH,
    `PRI_WMASK_FIFTH};
  int fld_reg [N] = '{1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 4, 4, 4, 4};
  int fld_lo [N] = '{`FLD_FREQ_SYNTH, `FLD_RX_FULL, `FLD_RX_ERROR, `FLD_TX_IDLE,
    `FLD_TX_EMPTY, `FLD_SS_TX_EMPTY, `FLD_SS_RX_FULL, `FLD_PORT_A, `FLD_CONV_A,
    `FLD_TIMER3, `FLD_TIMER2, `FLD_TIMER1, `FLD_TIMER0, `FLD_TWOWIRE,
    `FLD_PULSE_FAULT, `FLD_PULSE_RELOAD, `FLD_CONV_ZERO, `FLD_CONV_B};

  // ----------------------------------------
  // Clock, instances and hang guard
  // ----------------------------------------
  always #2.5 pclk = ~pclk;

  irq_source_model #(.NUM_SRC(N)) irq_source_model_inst (.pclk(pclk), .presetn(presetn),
    .pattern(irq_pattern), .src_irq(src_irq));

  irq_priority_level_config irq_priority_level_config_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .src_irq(src_irq), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_req(src_req));

  // Whole run is some sixty transfers; the ceiling leaves wide margin
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] addr_of(input int idx);
    return {idx[5:0], 2'h0};
  endfunction

  task automatic write_img();
    for (int r = 1; r <= 4; r++) apb(1'b1, addr_of(r), {16'h0, img[r]}, 4'hF);
  endtask

  task automatic read_img();
    for (int r = 1; r <= 4; r++) begin
      apb(1'b0, addr_of(r), 32'h0, 4'h0);
      check(rd, {16'h0, img[r] & wmask[r]});
      check({31'h0, err}, 32'h0);
    end
  endtask

  // Expected requests from the register image; idle sources show no request
  task automatic check_outputs();
    logic [1:0] code;
    repeat (3) @(posedge pclk);
    #1;
    for (int i = 0; i < N; i++) begin
      code = img[fld_reg[i]][fld_lo[i] +: 2];
      if (code == `PRI_CODE_OFF) check({29'h0, src_req[i]}, 32'h0);
      else if (irq_pattern[i]) check({29'h0, src_req[i]}, {29'h0, 1'b1, code - 2'h1});
      else check({31'h0, src_req[i].active}, 32'h0);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    for (int r = 1; r <= 4; r++) img[r] = `PRI_RESET;
    read_img();
    check_outputs();
    $display("test reset done");
  endtask

  // Every source gets each of the three enabled codes, neighbours always differ
  task automatic test_levels();
    for (int c = 0; c < 3; c++) begin
      for (int r = 1; r <= 4; r++) img[r] = 16'h0000;
      for (int i = 0; i < N; i++) img[fld_reg[i]][fld_lo[i] +: 2] = 2'((i + c) % 3 + 1);
      write_img();
      read_img();
      irq_pattern <= '1;
      check_outputs();
      irq_pattern <= 18'h2AAAA;
      check_outputs();
    end
    $display("test levels done");
  endtask

  task automatic test_reserved_strobe();
    for (int r = 1; r <= 4; r++) img[r] = 16'hFFFF;
    write_img();
    read_img();
    apb(1'b1, addr_of(2), 32'h0, 4'h1);
    img[2] = 16'hFF00;
    apb(1'b1, addr_of(3), 32'h0, 4'h2);
    img[3] = 16'h00FF;
    read_img();
    for (int r = 1; r <= 4; r++) img[r] = 16'h0000;
    write_img();
    irq_pattern <= '1;
    check_outputs();
    $display("test reserved and strobe done");
  endtask

  // Holes answer with an error, read zero and leave every register alone
  task automatic test_unmapped();
    apb(1'b1, 8'h14, 32'hFFFF, 4'hF);
    check({31'h0, err}, 32'h1);
    apb(1'b1, 8'h00, 32'hFFFF, 4'hF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    // Ready and error stand one cycle only
    @(posedge pclk);
    check({30'h0, pready, pslverr}, 32'h0);
    read_img();
    check_outputs();
    $display("test unmapped done");
  endtask

  // A reset in mid-run must clear programmed levels and drop every request
  task automatic test_midrun_reset();
    for (int r = 1; r <= 4; r++) img[r] = 16'hFFFF;
    write_img();
    irq_pattern <= '1;
    check_outputs();
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    for (int r = 1; r <= 4; r++) img[r] = `PRI_RESET;
    read_img();
    check_outputs();
    $display("test midrun reset done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_levels();
    test_reserved_strobe();
    test_unmapped();
    test_midrun_reset();
    complete_run();
  end
endmodule // tb_irq_priority_level_config
